// ### include/bsgl_pkg.sv
// Package with register map, field layout, reset values and carrier types for the loop and gain config bank.
package bsgl_pkg;
	localparam logic [7:0] BSGL_CLOCK_RECOVERY_ADDR = 8'h19;
	localparam logic [7:0] BSGL_GAIN_LIMIT_ADDR = 8'h1A;
	localparam logic [7:0] BSGL_CLOCK_RECOVERY_RESET = 8'h6C;
	localparam logic [7:0] BSGL_GAIN_LIMIT_RESET = 8'h03;
	localparam int BSGL_PRE_KI_POS = 6;
	localparam int BSGL_PRE_KP_POS = 4;
	localparam int BSGL_POST_KI_POS = 3;
	localparam int BSGL_POST_KP_POS = 2;
	localparam int BSGL_LIMIT_POS = 0;
	localparam int BSGL_DGAIN_POS = 6;
	localparam int BSGL_FGAIN_POS = 3;
	localparam int BSGL_TARGET_POS = 0;
	// Loop gains in units of half the base gain, so K/2 is 1 and 4K is 8.
	localparam logic [3:0] BSGL_HALF_BASE = 4'h1;
	localparam logic [3:0] BSGL_ONE_BASE = 4'h2;
	// Rate offset limit in units of 1/1000 percent.
	localparam logic [13:0] BSGL_LIMIT_1 = 14'h0C35;
	localparam logic [13:0] BSGL_LIMIT_2 = 14'h186A;
	localparam logic [13:0] BSGL_LIMIT_3 = 14'h30D4;

	typedef struct packed {
		logic [1:0] pre_sync_integral_gain;
		logic [1:0] pre_sync_proportional_gain;
		logic post_sync_integral_gain;
		logic post_sync_proportional_gain;
		logic [1:0] rate_offset_saturation;
	} bsgl_clock_recovery_type;

	typedef struct packed {
		logic [1:0] digital_gain_ceiling;
		logic [2:0] front_amp_gain_ceiling;
		logic [2:0] amplitude_target;
	} bsgl_gain_limit_type;

	typedef struct packed {
		logic [3:0] integral_gain;
		logic [3:0] proportional_gain;
		logic [13:0] rate_limit;
		logic rate_comp_enable;
		logic loop_frozen;
	} bsgl_loop_ctrl_type;

	typedef struct packed {
		logic [1:0] digital_steps_blocked;
		logic [7:0] front_amp_backoff;
		logic [5:0] amplitude_target_db;
	} bsgl_agc_ctrl_type;
endpackage : bsgl_pkg

// ### verilog/bsgl_config.sv
// Loop gain and gain limit configuration registers with decoded controls for demodulator and AGC.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Before sync, integral gain is one to four times base, from a 2-bit code.
// - Before sync, proportional gain is one to four times base, from a 2-bit code.
// - After sync, integral bit 0 keeps pre-sync gain, 1 uses half base.
// - After sync, proportional bit 0 keeps pre-sync gain, 1 uses base gain.
// - Rate offset compensation clamps to 0, 3.125, 6.25 or 12.5 percent.
// - Digital amplifier ceiling code forbids zero to three highest gain steps.
// - Front-end gain ceiling code 0 is full, down to 17.1 dB at 7.
// - AGC amplitude target codes map to 24 through 42 dB.
// - After reset no rate offset compensation is performed.
// - With the gate bit set, loops stay frozen until carrier sense asserts.
module bsgl_config
	import bsgl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic reg_write,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic sync_found,
	input wire logic rx_restart,
	input wire logic carrier_sense,
	input wire logic loop_freeze_gate,
	output bsgl_loop_ctrl_type loop_ctrl,
	output bsgl_agc_ctrl_type agc_ctrl
);
	bsgl_clock_recovery_type clock_recovery_config, next_clock_recovery_config;
	bsgl_gain_limit_type gain_limit_target_config, next_gain_limit_target_config;
	logic [7:0] next_reg_rdata;
	logic sync_held, next_sync_held;
	logic cs_seen, next_cs_seen;
	bsgl_loop_ctrl_type next_loop_ctrl;
	bsgl_agc_ctrl_type next_agc_ctrl;
	logic [3:0] pre_ki, pre_kp;
	logic post_phase;

	always_comb begin
		next_clock_recovery_config = clock_recovery_config;
		next_gain_limit_target_config = gain_limit_target_config;
		if (reg_write && reg_addr == BSGL_CLOCK_RECOVERY_ADDR) begin
			next_clock_recovery_config = bsgl_clock_recovery_type'(reg_wdata);
		end
		if (reg_write && reg_addr == BSGL_GAIN_LIMIT_ADDR) begin
			next_gain_limit_target_config = bsgl_gain_limit_type'(reg_wdata);
		end
		// Unmapped addresses read zero so software can probe safely.
		unique case (reg_addr)
			BSGL_CLOCK_RECOVERY_ADDR: next_reg_rdata = 8'(next_clock_recovery_config);
			BSGL_GAIN_LIMIT_ADDR: next_reg_rdata = 8'(next_gain_limit_target_config);
			default: next_reg_rdata = 8'h00;
		endcase
	end

	always_comb begin
		// Restart wins over a simultaneous sync so a fresh frame always starts pre-sync.
		next_sync_held = sync_held;
		if (rx_restart) begin
			next_sync_held = 1'b0;
		end else if (sync_found) begin
			next_sync_held = 1'b1;
		end
		next_cs_seen = cs_seen;
		if (rx_restart) begin
			next_cs_seen = carrier_sense;
		end else if (carrier_sense) begin
			next_cs_seen = 1'b1;
		end
	end

	always_comb begin
		pre_ki = {1'b0, clock_recovery_config.pre_sync_integral_gain, 1'b0} + BSGL_ONE_BASE;
		pre_kp = {1'b0, clock_recovery_config.pre_sync_proportional_gain, 1'b0} + BSGL_ONE_BASE;
		post_phase = !rx_restart && (sync_held || sync_found);
		next_loop_ctrl.integral_gain = pre_ki;
		next_loop_ctrl.proportional_gain = pre_kp;
		if (post_phase && clock_recovery_config.post_sync_integral_gain) begin
			next_loop_ctrl.integral_gain = BSGL_HALF_BASE;
		end
		if (post_phase && clock_recovery_config.post_sync_proportional_gain) begin
			next_loop_ctrl.proportional_gain = BSGL_ONE_BASE;
		end
		unique case (clock_recovery_config.rate_offset_saturation)
			2'h0: next_loop_ctrl.rate_limit = 14'h0000;
			2'h1: next_loop_ctrl.rate_limit = BSGL_LIMIT_1;
			2'h2: next_loop_ctrl.rate_limit = BSGL_LIMIT_2;
			2'h3: next_loop_ctrl.rate_limit = BSGL_LIMIT_3;
		endcase
		next_loop_ctrl.rate_comp_enable = clock_recovery_config.rate_offset_saturation != 2'h0;
		next_loop_ctrl.loop_frozen = loop_freeze_gate && !(carrier_sense || (cs_seen && !rx_restart));
		next_agc_ctrl.digital_steps_blocked = gain_limit_target_config.digital_gain_ceiling;
		// Backoff in tenths of a dB; the steps are approximate and uneven.
		unique case (gain_limit_target_config.front_amp_gain_ceiling)
			3'h0: next_agc_ctrl.front_amp_backoff = 8'h00;
			3'h1: next_agc_ctrl.front_amp_backoff = 8'h1A;
			3'h2: next_agc_ctrl.front_amp_backoff = 8'h3D;
			3'h3: next_agc_ctrl.front_amp_backoff = 8'h4A;
			3'h4: next_agc_ctrl.front_amp_backoff = 8'h5C;
			3'h5: next_agc_ctrl.front_amp_backoff = 8'h73;
			3'h6: next_agc_ctrl.front_amp_backoff = 8'h92;
			3'h7: next_agc_ctrl.front_amp_backoff = 8'hAB;
		endcase
		unique case (gain_limit_target_config.amplitude_target)
			3'h0: next_agc_ctrl.amplitude_target_db = 6'h18;
			3'h1: next_agc_ctrl.amplitude_target_db = 6'h1B;
			3'h2: next_agc_ctrl.amplitude_target_db = 6'h1E;
			3'h3: next_agc_ctrl.amplitude_target_db = 6'h21;
			3'h4: next_agc_ctrl.amplitude_target_db = 6'h24;
			3'h5: next_agc_ctrl.amplitude_target_db = 6'h26;
			3'h6: next_agc_ctrl.amplitude_target_db = 6'h28;
			3'h7: next_agc_ctrl.amplitude_target_db = 6'h2A;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			clock_recovery_config <= bsgl_clock_recovery_type'(BSGL_CLOCK_RECOVERY_RESET);
			gain_limit_target_config <= bsgl_gain_limit_type'(BSGL_GAIN_LIMIT_RESET);
			reg_rdata <= 8'h00;
			sync_held <= 1'b0;
			cs_seen <= 1'b0;
			loop_ctrl <= '0;
			agc_ctrl <= '0;
		end else begin
			clock_recovery_config <= next_clock_recovery_config;
			gain_limit_target_config <= next_gain_limit_target_config;
			reg_rdata <= next_reg_rdata;
			sync_held <= next_sync_held;
			cs_seen <= next_cs_seen;
			loop_ctrl <= next_loop_ctrl;
			agc_ctrl <= next_agc_ctrl;
		end
	end

	chk_rdata_echo: assert property (@(posedge core_clk) disable iff (!rst_b)
		reg_write && reg_addr == BSGL_GAIN_LIMIT_ADDR |=> reg_rdata == $past(reg_wdata))
		else $error("Register read does not echo the write.");
	chk_reset_no_comp: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(rst_b) |-> clock_recovery_config.rate_offset_saturation == 2'h0)
		else $error("Rate compensation not off after reset.");
	chk_limit_off_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		clock_recovery_config.rate_offset_saturation == 2'h0 |=> loop_ctrl.rate_limit == 14'h0000)
		else $error("Rate limit nonzero with compensation disabled.");
	chk_pre_ki_map: assert property (@(posedge core_clk) disable iff (!rst_b)
		!post_phase |=> loop_ctrl.integral_gain == 4'({1'b0, $past(clock_recovery_config.pre_sync_integral_gain), 1'b0} + 4'h2))
		else $error("Pre-sync integral gain wrong.");
	chk_pre_kp_range: assert property (@(posedge core_clk) disable iff (!rst_b)
		!post_phase |=> loop_ctrl.proportional_gain == 4'({1'b0, $past(clock_recovery_config.pre_sync_proportional_gain), 1'b0} + 4'h2))
		else $error("Pre-sync proportional gain wrong.");
	chk_post_ki_half: assert property (@(posedge core_clk) disable iff (!rst_b)
		sync_found && !rx_restart && clock_recovery_config.post_sync_integral_gain |=> loop_ctrl.integral_gain == 4'h1)
		else $error("Post-sync integral gain not half base.");
	chk_post_kp_base: assert property (@(posedge core_clk) disable iff (!rst_b)
		sync_found && !rx_restart && clock_recovery_config.post_sync_proportional_gain |=> loop_ctrl.proportional_gain == 4'h2)
		else $error("Post-sync proportional gain not base.");
	chk_restart_pre: assert property (@(posedge core_clk) disable iff (!rst_b)
		rx_restart ##1 !sync_found && !rx_restart |-> !post_phase)
		else $error("Restart did not return to pre-sync gains.");
	chk_freeze_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
		loop_freeze_gate && rx_restart && !carrier_sense |=> loop_ctrl.loop_frozen)
		else $error("Loops not frozen while waiting for carrier.");
	chk_target_top: assert property (@(posedge core_clk) disable iff (!rst_b)
		gain_limit_target_config.amplitude_target == 3'h7 |=> agc_ctrl.amplitude_target_db == 6'h2A)
		else $error("Amplitude target code 7 not 42 dB.");
	chk_digital_cap: assert property (@(posedge core_clk) disable iff (!rst_b)
		1'b1 |=> agc_ctrl.digital_steps_blocked == $past(gain_limit_target_config.digital_gain_ceiling))
		else $error("Digital gain cap not applied.");
	chk_front_cap: assert property (@(posedge core_clk) disable iff (!rst_b)
		gain_limit_target_config.front_amp_gain_ceiling == 3'h0 |=> agc_ctrl.front_amp_backoff == 8'h00)
		else $error("Front-end full gain not allowed at code 0.");
	// Each check except chk_reset_no_comp and chk_restart_pre looks one edge after its cause, since every control output is registered.
	chk_recovery_echo: assert property (@(posedge core_clk) disable iff (!rst_b)
		reg_write && reg_addr == BSGL_CLOCK_RECOVERY_ADDR |=> reg_rdata == $past(reg_wdata))
		else $error("Clock recovery register read does not echo the write.");
	chk_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		reg_addr != BSGL_CLOCK_RECOVERY_ADDR && reg_addr != BSGL_GAIN_LIMIT_ADDR |=> reg_rdata == 8'h00)
		else $error("Unmapped address does not read zero.");
	chk_unmapped_keep: assert property (@(posedge core_clk) disable iff (!rst_b)
		reg_write && reg_addr != BSGL_CLOCK_RECOVERY_ADDR && reg_addr != BSGL_GAIN_LIMIT_ADDR |=>
		clock_recovery_config == $past(clock_recovery_config) && gain_limit_target_config == $past(gain_limit_target_config))
		else $error("Unmapped write changed a register.");
	chk_limit_low: assert property (@(posedge core_clk) disable iff (!rst_b)
		clock_recovery_config.rate_offset_saturation == 2'h1 |=> loop_ctrl.rate_limit == 14'h0C35)
		else $error("Rate limit code 1 not 3.125 percent.");
	chk_limit_mid: assert property (@(posedge core_clk) disable iff (!rst_b)
		clock_recovery_config.rate_offset_saturation == 2'h2 |=> loop_ctrl.rate_limit == 14'h186A)
		else $error("Rate limit code 2 not 6.25 percent.");
	chk_limit_high: assert property (@(posedge core_clk) disable iff (!rst_b)
		clock_recovery_config.rate_offset_saturation == 2'h3 |=> loop_ctrl.rate_limit == 14'h30D4)
		else $error("Rate limit code 3 not 12.5 percent.");
	chk_comp_enable: assert property (@(posedge core_clk) disable iff (!rst_b)
		1'b1 |=> loop_ctrl.rate_comp_enable == ($past(clock_recovery_config.rate_offset_saturation) != 2'h0))
		else $error("Rate compensation enable does not follow the saturation code.");
	chk_reset_comp_off: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(rst_b) |=> !loop_ctrl.rate_comp_enable)
		else $error("Rate compensation enabled right after reset.");
	chk_front_floor: assert property (@(posedge core_clk) disable iff (!rst_b)
		gain_limit_target_config.front_amp_gain_ceiling == 3'h7 |=> agc_ctrl.front_amp_backoff == 8'hAB)
		else $error("Front-end ceiling code 7 not 17.1 dB down.");
	chk_front_mid: assert property (@(posedge core_clk) disable iff (!rst_b)
		gain_limit_target_config.front_amp_gain_ceiling == 3'h4 |=> agc_ctrl.front_amp_backoff == 8'h5C)
		else $error("Front-end ceiling code 4 not 9.2 dB down.");
	chk_target_floor: assert property (@(posedge core_clk) disable iff (!rst_b)
		gain_limit_target_config.amplitude_target == 3'h0 |=> agc_ctrl.amplitude_target_db == 6'h18)
		else $error("Amplitude target code 0 not 24 dB.");
	chk_post_ki_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		sync_held && !rx_restart && clock_recovery_config.post_sync_integral_gain |=> loop_ctrl.integral_gain == 4'h1)
		else $error("Post-sync integral gain not held at half base.");
	chk_post_ki_keep: assert property (@(posedge core_clk) disable iff (!rst_b)
		post_phase && !clock_recovery_config.post_sync_integral_gain |=>
		loop_ctrl.integral_gain == 4'({1'b0, $past(clock_recovery_config.pre_sync_integral_gain), 1'b0} + 4'h2))
		else $error("Post-sync integral gain did not keep the pre-sync value.");
	chk_post_kp_keep: assert property (@(posedge core_clk) disable iff (!rst_b)
		post_phase && !clock_recovery_config.post_sync_proportional_gain |=>
		loop_ctrl.proportional_gain == 4'({1'b0, $past(clock_recovery_config.pre_sync_proportional_gain), 1'b0} + 4'h2))
		else $error("Post-sync proportional gain did not keep the pre-sync value.");
	chk_freeze_release: assert property (@(posedge core_clk) disable iff (!rst_b)
		carrier_sense |=> !loop_ctrl.loop_frozen)
		else $error("Loops still frozen after carrier sense.");
	chk_gate_off: assert property (@(posedge core_clk) disable iff (!rst_b)
		!loop_freeze_gate |=> !loop_ctrl.loop_frozen)
		else $error("Loops frozen with the gate bit clear.");
	chk_restart_ki: assert property (@(posedge core_clk) disable iff (!rst_b)
		rx_restart |=> loop_ctrl.integral_gain == 4'({1'b0, $past(clock_recovery_config.pre_sync_integral_gain), 1'b0} + 4'h2))
		else $error("Restart did not restore the pre-sync integral gain.");
	chk_restart_kp: assert property (@(posedge core_clk) disable iff (!rst_b)
		rx_restart |=> loop_ctrl.proportional_gain == 4'({1'b0, $past(clock_recovery_config.pre_sync_proportional_gain), 1'b0} + 4'h2))
		else $error("Restart did not restore the pre-sync proportional gain.");
endmodule : bsgl_config
`default_nettype wire

// ### sim/tb.sv
// Self-checking testbench for the loop gain and gain limit configuration bank.
`timescale 1ns/10ps
`default_nettype none
module tb
	import bsgl_pkg::*;
;
	logic core_clk, rst_b, reg_write, sync_found, rx_restart, carrier_sense, loop_freeze_gate;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	bsgl_loop_ctrl_type loop_ctrl;
	bsgl_agc_ctrl_type agc_ctrl;
	int fail_count = 0;
	int samples_checked = 0;
	int cr = 8'h6C, gl = 8'h03, post = 0, cs_seen = 0;
	logic [31:0] lfsr = 32'h8363;
	int lim_tab[4] = '{0, 3125, 6250, 12500};
	int amp_tab[8] = '{0, 26, 61, 74, 92, 115, 146, 171};
	int tgt_tab[8] = '{24, 27, 30, 33, 36, 38, 40, 42};
	bsgl_config i_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_write(reg_write), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sync_found(sync_found), .rx_restart(rx_restart),
		.carrier_sense(carrier_sense), .loop_freeze_gate(loop_freeze_gate), .loop_ctrl(loop_ctrl), .agc_ctrl(agc_ctrl));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next
	task automatic step(input int n);
		repeat (n) begin
			@(posedge core_clk);
			#1;
		end
	endtask : step
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	// The strobe is left high so that back-to-back writes never assign it twice in one step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		step(1);
		if (a == BSGL_CLOCK_RECOVERY_ADDR) cr = d;
		else if (a == BSGL_GAIN_LIMIT_ADDR) gl = d;
	endtask : wr
	task automatic status(input logic s, input logic r, input logic c);
		sync_found = s;
		rx_restart = r;
		carrier_sense = c;
		step(1);
		sync_found = 1'b0;
		rx_restart = 1'b0;
		carrier_sense = 1'b0;
		post = r ? 0 : (s ? 1 : post);
		cs_seen = c ? 1 : (r ? 0 : cs_seen);
	endtask : status
	task automatic check_all();
		int ki, kp, lim;
		ki = ((cr >> 6) & 3) * 2 + 2;
		kp = ((cr >> 4) & 3) * 2 + 2;
		if (post != 0 && ((cr >> 3) & 1) != 0) ki = 1;
		if (post != 0 && ((cr >> 2) & 1) != 0) kp = 2;
		lim = lim_tab[cr & 3];
		cmp("loop_ctrl", {8'h0, 4'(ki), 4'(kp), 14'(lim), lim != 0, loop_freeze_gate && cs_seen == 0}, 32'(loop_ctrl));
		cmp("agc_ctrl", {16'h0, 2'(gl >> 6), 8'(amp_tab[(gl >> 3) & 7]), 6'(tgt_tab[gl & 7])}, 32'(agc_ctrl));
		reg_addr = BSGL_CLOCK_RECOVERY_ADDR;
		step(2);
		cmp("clock_recovery_config", 32'(cr), 32'(reg_rdata));
		reg_addr = BSGL_GAIN_LIMIT_ADDR;
		step(2);
		cmp("gain_limit_target_config", 32'(gl), 32'(reg_rdata));
	endtask : check_all
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up
	// The whole sequence needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge core_clk);
		fail_count++;
		wrap_up();
	end
	initial begin
		reg_write = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		sync_found = 1'b0;
		rx_restart = 1'b0;
		carrier_sense = 1'b0;
		loop_freeze_gate = 1'b0;
		rst_b = 1'b0;
		step(16);
		rst_b = 1'b1;
		step(2);
		check_all();
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			wr(BSGL_CLOCK_RECOVERY_ADDR, {i[1:0], ~i[1:0], i[1:0] ^ lfsr[1:0], i[1:0]});
			wr(BSGL_GAIN_LIMIT_ADDR, {i[1:0], i[2:0], ~i[2:0]});
			reg_write = 1'b0;
			step(2);
			check_all();
			status(1'b1, 1'b0, 1'b0);
			check_all();
			status(1'b1, 1'b1, 1'b0);
			check_all();
		end
		$display("test field codes and sync gains done");
		wr(8'h1B, 8'hFF);
		wr(8'h18, 8'hFF);
		reg_write = 1'b0;
		step(2);
		check_all();
		reg_addr = 8'h1B;
		step(2);
		cmp("unmapped read", 32'h0, 32'(reg_rdata));
		$display("test unmapped access done");
		loop_freeze_gate = 1'b1;
		status(1'b0, 1'b1, 1'b0);
		step(1);
		check_all();
		status(1'b0, 1'b0, 1'b1);
		step(1);
		check_all();
		check_all();
		status(1'b0, 1'b1, 1'b0);
		step(1);
		check_all();
		status(1'b0, 1'b1, 1'b1);
		step(1);
		check_all();
		loop_freeze_gate = 1'b0;
		step(2);
		check_all();
		$display("test loop freeze done");
		rst_b = 1'b0;
		step(2);
		rst_b = 1'b1;
		cr = BSGL_CLOCK_RECOVERY_RESET;
		gl = BSGL_GAIN_LIMIT_RESET;
		post = 0;
		cs_seen = 0;
		step(2);
		check_all();
		$display("test mid-run reset done");
		wrap_up();
	end
endmodule : tb
`default_nettype wire
